// [core/branch_trace_sampler.sv]
// Purpose: branch trace stack plus precise branch event counter and sampler
// Assumes: retirement reports at most one branch per clock; Avalon-MM register port
// Notes: reads take one wait cycle, writes none
`timescale 1ns/1ps
`default_nettype none
`include "brtrace_consts.svh"
module branch_trace_sampler
(
    input  wire logic                       clock,
    input  wire logic                       rstn,
    input  wire logic [4:0]                 address,
    input  wire logic                       read,
    input  wire logic                       write,
    input  wire logic [3:0]                 byteenable,
    input  wire logic [31:0]                writedata,
    output logic      [31:0]                readdata,
    output logic                            waitrequest,
    input  wire logic                       retire_valid,
    input  wire logic                       retire_taken,
    input  wire logic                       retire_mispredicted,
    input  wire logic                       retire_ring0,
    input  wire brtrace_pkg::branch_kind_t  retire_kind,
    input  wire logic [`ADDR_W-1:0]         retire_source,
    input  wire logic [`ADDR_W-1:0]         retire_target,
    input  wire logic [`ADDR_W-1:0]         retire_next_ip,
    input  wire logic [`GPR_W-1:0]          retire_gpr,
    output logic                            sample_valid,
    output logic [`ADDR_W-1:0]              sample_ip,
    output logic [`GPR_W-1:0]               sample_gpr,
    output logic                            perf_monitor_interrupt
);
    import brtrace_pkg::*;

    localparam int SHADOW_CYC = `SHADOW_CYCLES;
    localparam int FREEZE_CYC = `FREEZE_CYCLES;

    function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_be

    function automatic logic excluded(input logic [`FILTER_W-1:0] m, input logic ring0,
                                      input branch_kind_t k);
        logic [`FILTER_W-1:0] sh;
        sh = m >> `FILTER_TYPE_LSB;
        return (m[0] & ring0) | (m[1] & ~ring0) | sh[k];
    endfunction : excluded

    function automatic logic event_match(input logic [`EVTSEL_W-1:0] sel, input branch_kind_t k,
                                         input logic misp);
        logic [7:0] um;
        logic       hit;
        um  = sel[`EVTSEL_UMASK_LSB +: 8];
        hit = 1'b0;
        if (um == `UMASK_COND)
        begin
            hit = (k == kind_cond);
        end
        else if (um == `UMASK_CALL)
        begin
            hit = (k == kind_rel_call) || (k == kind_ind_call);
        end
        else if (um == `UMASK_ANY)
        begin
            hit = 1'b1;
        end
        return sel[`EVTSEL_EN_BIT] && (sel[`EVTSEL_CODE_LSB +: 8] == `EVT_CODE_BRANCH)
               && hit && (misp || !sel[`EVTSEL_MISP_BIT]);
    endfunction : event_match

    logic [`FILTER_W-1:0]   filter_q, filter_d;
    logic [`EVTSEL_W-1:0]   evtsel_q, evtsel_d;
    logic [31:0]            count_q, count_d;
    logic [`IDX_W-1:0]      rdidx_q, rdidx_d;
    logic [`IDX_W-1:0]      head_q, head_d;
    logic                   frozen_q, frozen_d;
    logic [`DLY_W-1:0]      frz_cnt_q, frz_cnt_d;
    logic                   frz_pend_q, frz_pend_d;
    sample_state_t          state_q, state_d;
    logic [`DLY_W-1:0]      shd_cnt_q, shd_cnt_d;
    logic                   rd_ack_q, rd_ack_d;
    logic [31:0]            readdata_d;
    logic                   sample_d;
    logic [`ADDR_W-1:0]     sample_ip_d;
    logic [`GPR_W-1:0]      sample_gpr_d;
    logic [2*`ADDR_W-1:0]   ram_rdata;
    logic                   rec_wr;
    logic                   evt_hit;
    logic                   ovf;
    logic                   reg_wr;

    assign reg_wr  = write;
    assign rec_wr  = retire_valid && retire_taken && !frozen_q
                     && !excluded(filter_q, retire_ring0, retire_kind);
    assign evt_hit = retire_valid && event_match(evtsel_q, retire_kind, retire_mispredicted);
    assign ovf     = evt_hit && (count_q == 32'hffffffff);
    assign waitrequest = read && !rd_ack_q;

    trace_ram u_ram
    (
        .clock     (clock),
        .rstn      (rstn),
        .wr_en     (rec_wr),
        .wr_addr   (head_q),
        .wr_data   ({retire_source, retire_target}),
        .rd_addr   (rdidx_q),
        .rd_data_q (ram_rdata)
    );

    // register file and bus answer
    always_comb
    begin
        filter_d   = filter_q;
        evtsel_d   = evtsel_q;
        rdidx_d    = rdidx_q;
        count_d    = evt_hit ? count_q + 32'h1 : count_q;
        rd_ack_d   = read && !rd_ack_q;
        readdata_d = readdata;
        if (reg_wr && address == `OFS_FILTER)
        begin
            filter_d = `FILTER_W'(merge_be({23'h0, filter_q}, writedata, byteenable));
        end
        else if (reg_wr && address == `OFS_EVTSEL)
        begin
            evtsel_d = `EVTSEL_W'(merge_be({14'h0, evtsel_q}, writedata, byteenable));
        end
        else if (reg_wr && address == `OFS_COUNT)
        begin
            count_d = merge_be(count_q, writedata, byteenable);
        end
        else if (reg_wr && address == `OFS_RDIDX)
        begin
            rdidx_d = `IDX_W'(merge_be({28'h0, rdidx_q}, writedata, byteenable));
        end
        if (read && !rd_ack_q)
        begin
            if (address == `OFS_FILTER)
            begin
                readdata_d = {23'h0, filter_q};
            end
            else if (address == `OFS_EVTSEL)
            begin
                readdata_d = {14'h0, evtsel_q};
            end
            else if (address == `OFS_COUNT)
            begin
                readdata_d = count_q;
            end
            else if (address == `OFS_STATUS)
            begin
                readdata_d = {25'h0, state_q == st_shadow, state_q == st_armed, frozen_q, head_q};
            end
            else if (address == `OFS_RDIDX)
            begin
                readdata_d = {28'h0, rdidx_q};
            end
            else if (address == `OFS_RDSRC)
            begin
                readdata_d = ram_rdata[2*`ADDR_W-1:`ADDR_W];
            end
            else if (address == `OFS_RDTGT)
            begin
                readdata_d = ram_rdata[`ADDR_W-1:0];
            end
            else
            begin
                readdata_d = 32'h0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            filter_q <= `FILTER_RESET;
            evtsel_q <= `EVTSEL_RESET;
            count_q  <= `COUNT_RESET;
            rdidx_q  <= '0;
            rd_ack_q <= 1'b0;
            readdata <= 32'h0;
        end
        else
        begin
            filter_q <= filter_d;
            evtsel_q <= evtsel_d;
            count_q  <= count_d;
            rdidx_q  <= rdidx_d;
            rd_ack_q <= rd_ack_d;
            readdata <= readdata_d;
        end
    end

    // trace stack position and freeze
    always_comb
    begin
        head_d     = rec_wr ? head_q + `IDX_W'(1) : head_q;
        frz_pend_d = frz_pend_q;
        frz_cnt_d  = frz_cnt_q;
        frozen_d   = frozen_q;
        if (reg_wr && address == `OFS_STATUS && byteenable[0] && writedata[`STATUS_FROZEN])
        begin
            frozen_d = 1'b0;
        end
        if (ovf && !frz_pend_q)
        begin
            frz_pend_d = 1'b1;
            frz_cnt_d  = `DLY_W'(FREEZE_CYC - 1);
        end
        else if (frz_pend_q)
        begin
            // stack keeps recording until the countdown ends
            frz_cnt_d = frz_cnt_q - `DLY_W'(1);
            if (frz_cnt_q == '0)
            begin
                frz_pend_d = 1'b0;
                frozen_d   = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            head_q     <= '0;
            frozen_q   <= 1'b0;
            frz_pend_q <= 1'b0;
            frz_cnt_q  <= '0;
        end
        else
        begin
            head_q     <= head_d;
            frozen_q   <= frozen_d;
            frz_pend_q <= frz_pend_d;
            frz_cnt_q  <= frz_cnt_d;
        end
    end

    // precise sampling: overflow, shadow, armed, sample
    always_comb
    begin
        state_d      = state_q;
        shd_cnt_d    = shd_cnt_q;
        sample_d     = 1'b0;
        sample_ip_d  = sample_ip;
        sample_gpr_d = sample_gpr;
        case (state_q)
            st_count:
            begin
                if (ovf)
                begin
                    state_d   = st_shadow;
                    shd_cnt_d = `DLY_W'(SHADOW_CYC - 1);
                end
            end
            st_shadow:
            begin
                // events here are lost on purpose: this is the arming latency
                shd_cnt_d = shd_cnt_q - `DLY_W'(1);
                if (shd_cnt_q == '0)
                begin
                    state_d = st_armed;
                end
            end
            st_armed:
            begin
                if (evt_hit)
                begin
                    sample_d     = 1'b1;
                    sample_ip_d  = retire_taken ? retire_target : retire_next_ip;
                    sample_gpr_d = retire_gpr;
                    state_d      = st_count;
                end
            end
            default:
            begin
                state_d = st_count;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q                <= st_count;
            shd_cnt_q              <= '0;
            sample_valid           <= 1'b0;
            perf_monitor_interrupt <= 1'b0;
            sample_ip              <= '0;
            sample_gpr             <= '0;
        end
        else
        begin
            state_q                <= state_d;
            shd_cnt_q              <= shd_cnt_d;
            sample_valid           <= sample_d;
            perf_monitor_interrupt <= sample_d;
            sample_ip              <= sample_ip_d;
            sample_gpr             <= sample_gpr_d;
        end
    end

    // checks
    sequence s_overflow;
        ovf && state_q == st_count;
    endsequence

    sequence s_wait_shadow;
        !sample_d [*4];
    endsequence

    property p_trace_write;
        @(posedge clock) disable iff (!rstn)
        rec_wr |=> head_q == $past(head_q) + `IDX_W'(1);
    endproperty
    a_trace_write: assert property (p_trace_write) else $error("taken branch did not advance stack");

    property p_wrap;
        @(posedge clock) disable iff (!rstn)
        rec_wr && head_q == 4'hf |=> head_q == 4'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("stack position did not wrap");

    property p_ring_filter;
        @(posedge clock) disable iff (!rstn)
        retire_valid && ((filter_q[0] && retire_ring0) || (filter_q[1] && !retire_ring0)) |=> $stable(head_q);
    endproperty
    a_ring_filter: assert property (p_ring_filter) else $error("ring filter ignored");

    property p_type_filter;
        @(posedge clock) disable iff (!rstn)
        retire_valid && filter_q[`FILTER_TYPE_LSB + retire_kind] |=> $stable(head_q);
    endproperty
    a_type_filter: assert property (p_type_filter) else $error("type filter ignored");

    property p_no_filter;
        @(posedge clock) disable iff (!rstn)
        filter_q == '0 && retire_valid && retire_taken && !frozen_q |=> head_q != $past(head_q);
    endproperty
    a_no_filter: assert property (p_no_filter) else $error("unfiltered branch lost");

    property p_sample_ip;
        @(posedge clock) disable iff (!rstn)
        sample_d |=> sample_ip == ($past(retire_taken) ? $past(retire_target) : $past(retire_next_ip));
    endproperty
    a_sample_ip: assert property (p_sample_ip) else $error("sample pointer wrong");

    property p_shadow;
        @(posedge clock) disable iff (!rstn)
        s_overflow |=> s_wait_shadow;
    endproperty
    a_shadow: assert property (p_shadow) else $error("sample taken inside shadow");

    property p_freeze;
        @(posedge clock) disable iff (!rstn)
        s_overflow and (!frz_pend_q) |=> ##FREEZE_CYC frozen_q;
    endproperty
    a_freeze: assert property (p_freeze) else $error("stack did not freeze after delay");

    property p_gpr;
        @(posedge clock) disable iff (!rstn)
        sample_d |=> sample_gpr == $past(retire_gpr) && sample_valid && perf_monitor_interrupt;
    endproperty
    a_gpr: assert property (p_gpr) else $error("sample record or interrupt missing");

    property p_mispredict;
        @(posedge clock) disable iff (!rstn)
        evtsel_q[`EVTSEL_MISP_BIT] && retire_valid && !retire_mispredicted |=> count_q == $past(count_q)
            || $past(reg_wr);
    endproperty
    a_mispredict: assert property (p_mispredict) else $error("predicted branch counted");
endmodule : branch_trace_sampler
`default_nettype wire

// [core/brtrace_consts.svh]
// Purpose: constants of the branch trace stack and precise branch sampler
// Assumes: 40 MHz core clock, 32-bit instruction addresses
// Notes: numbers used by the design live only here
`ifndef BRTRACE_CONSTS_SVH
`define BRTRACE_CONSTS_SVH

`define ADDR_W           32
`define GPR_W            128
`define DEPTH            16
`define IDX_W            4
`define FILTER_W         9
`define FILTER_TYPE_LSB  2

`define EVT_CODE_BRANCH  8'hc4
`define UMASK_COND       8'h01
`define UMASK_CALL       8'h02
`define UMASK_ANY        8'h04

`define OFS_FILTER       5'h00
`define OFS_EVTSEL       5'h04
`define OFS_COUNT        5'h08
`define OFS_STATUS       5'h0c
`define OFS_RDIDX        5'h10
`define OFS_RDSRC        5'h14
`define OFS_RDTGT        5'h18

`define EVTSEL_CODE_LSB  0
`define EVTSEL_UMASK_LSB 8
`define EVTSEL_MISP_BIT  16
`define EVTSEL_EN_BIT    17
`define EVTSEL_W         18
`define STATUS_FROZEN    4
`define STATUS_ARMED     5
`define STATUS_SHADOW    6

`define FILTER_RESET     9'h000
`define EVTSEL_RESET     18'h00000
`define COUNT_RESET      32'h00000000

`define CLK_PERIOD_NS    25
`define SHADOW_NS        100
`define FREEZE_NS        75
`define SHADOW_CYCLES    ((`SHADOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FREEZE_CYCLES    ((`FREEZE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DLY_W            4

`endif

// [core/brtrace_pkg.sv]
// Purpose: types shared by the branch trace stack and sampler
// Assumes: nothing
// Notes: branch kind order matches filter bits 2 to 8
package brtrace_pkg;
    typedef enum logic [2:0] {
        kind_cond,
        kind_rel_call,
        kind_ind_call,
        kind_return,
        kind_ind_jump,
        kind_rel_jump,
        kind_far
    } branch_kind_t;

    typedef enum logic [1:0] {
        st_count,
        st_shadow,
        st_armed
    } sample_state_t;
endpackage : brtrace_pkg

// [core/trace_ram.sv]
// Purpose: storage of the sixteen source/target pairs
// Assumes: one write port, one read port, same clock
// Notes: read data is registered and follows rd_addr one cycle late
`timescale 1ns/1ps
`default_nettype none
`include "brtrace_consts.svh"
module trace_ram
(
    input  wire logic                       clock,
    input  wire logic                       rstn,
    input  wire logic                       wr_en,
    input  wire logic [`IDX_W-1:0]          wr_addr,
    input  wire logic [2*`ADDR_W-1:0]       wr_data,
    input  wire logic [`IDX_W-1:0]          rd_addr,
    output logic      [2*`ADDR_W-1:0]       rd_data_q
);
    logic [2*`ADDR_W-1:0] mem [`DEPTH];

    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // entries never written read back as unknown, so gate with a valid count upstream if needed
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_data_q <= '0;
        end
        else
        begin
            rd_data_q <= mem[rd_addr];
        end
    end
endmodule : trace_ram
`default_nettype wire

// [testbench/core_retire_model.sv]
// Purpose: retirement stage stand-in that reports one retired branch per call
// Assumes: the bench calls retire right after a clock edge
// Notes: idle data lines show inverted values, so stale data can never pass for fresh
`timescale 1ns/1ps
`default_nettype none
`include "brtrace_consts.svh"
module core_retire_model
(
    input  wire logic                  clock,
    output logic                       retire_valid,
    output logic                       retire_taken,
    output logic                       retire_mispredicted,
    output logic                       retire_ring0,
    output brtrace_pkg::branch_kind_t  retire_kind,
    output logic [`ADDR_W-1:0]         retire_source,
    output logic [`ADDR_W-1:0]         retire_target,
    output logic [`ADDR_W-1:0]         retire_next_ip,
    output logic [`GPR_W-1:0]          retire_gpr
);
    import brtrace_pkg::*;

    initial
    begin
        retire_valid = 1'b0;
        retire_taken = 1'b0;
        retire_mispredicted = 1'b0;
        retire_ring0 = 1'b0;
        retire_kind = kind_cond;
        retire_source = '0;
        retire_target = '0;
        retire_next_ip = '0;
        retire_gpr = '0;
    end

    // gap idles a few cycles first, so the core can be prompt or slow
    task retire(input logic tk, input logic mp, input logic r0, input branch_kind_t k,
                input logic [`ADDR_W-1:0] src, input logic [`ADDR_W-1:0] tgt,
                input logic [`GPR_W-1:0] gpr, input int gap);
        repeat (gap) @(posedge clock);
        @(posedge clock);
        retire_valid <= 1'b1;
        retire_taken <= tk;
        retire_mispredicted <= mp;
        retire_ring0 <= r0;
        retire_kind <= k;
        retire_source <= src;
        retire_target <= tgt;
        retire_next_ip <= src + 32'h4;
        retire_gpr <= gpr;
        @(posedge clock);
        retire_valid <= 1'b0;
        retire_taken <= ~tk;
        retire_mispredicted <= ~mp;
        retire_ring0 <= ~r0;
        retire_kind <= branch_kind_t'(~k);
        retire_source <= ~src;
        retire_target <= ~tgt;
        retire_next_ip <= ~src;
        retire_gpr <= ~gpr;
    endtask : retire
endmodule : core_retire_model
`default_nettype wire

// [testbench/branch_trace_sampler_tb.sv]
// Purpose: self-checking bench for the branch trace stack and precise sampler
// Assumes: registers over Avalon-MM, retired branches from core_retire_model
// Notes: expected values come from the branch numbering below, never from the design
`timescale 1ns/1ps
`default_nettype none
`include "brtrace_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module branch_trace_sampler_tb;
    import brtrace_pkg::*;
    logic               clock = 1'b0;
    logic               rstn = 1'b0;
    logic [4:0]         address = 5'h00;
    logic               read = 1'b0;
    logic               write = 1'b0;
    logic [3:0]         byteenable = 4'h0;
    logic [31:0]        writedata = 32'h0;
    wire  logic [31:0]  readdata;
    wire  logic         waitrequest;
    wire  logic         rv, rt, rm, r0w;
    branch_kind_t       rk;
    wire  logic [31:0]  rs, rtg, rn;
    wire  logic [127:0] rg;
    wire  logic         sample_valid, perf_monitor_interrupt;
    wire  logic [31:0]  sample_ip;
    wire  logic [127:0] sample_gpr;
    int                 n_fail = 0, n_tests = 0, cycles = 0, id = 0, exp_head = 0, n_samp = 0, n0;
    logic               slow = 1'b0;
    logic [31:0]        smp_ip = 32'h0, v;
    logic [127:0]       smp_gpr = '0;
    logic [7:0]         um_tab [3] = '{8'h01, 8'h02, 8'h04};
    logic [31:0]        all_tab [3] = '{32'h1, 32'h2, 32'h4};
    logic [31:0]        misp_tab [3] = '{32'h1, 32'h0, 32'h1};

    always #12.5 clock = ~clock;

    branch_trace_sampler DUT (.clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .retire_valid(rv), .retire_taken(rt), .retire_mispredicted(rm), .retire_ring0(r0w),
        .retire_kind(rk), .retire_source(rs), .retire_target(rtg), .retire_next_ip(rn),
        .retire_gpr(rg), .sample_valid(sample_valid), .sample_ip(sample_ip),
        .sample_gpr(sample_gpr), .perf_monitor_interrupt(perf_monitor_interrupt));

    core_retire_model u_core (.clock(clock), .retire_valid(rv), .retire_taken(rt), .retire_mispredicted(rm),
        .retire_ring0(r0w), .retire_kind(rk), .retire_source(rs), .retire_target(rtg),
        .retire_next_ip(rn), .retire_gpr(rg));

    function logic [31:0] src_of(input int n);
        return 32'h0000_1000 + 32'(n) * 32'h10;
    endfunction : src_of

    function logic [31:0] tgt_of(input int n);
        return 32'h0009_0000 + 32'(n) * 32'h20;
    endfunction : tgt_of

    function logic [127:0] gpr_of(input int n);
        return {src_of(n), tgt_of(n), ~src_of(n), ~tgt_of(n)};
    endfunction : gpr_of

    function logic [31:0] evt(input logic [7:0] um, input logic m, input logic [7:0] code);
        return {14'h0, 1'b1, m, um, code};
    endfunction : evt

    task end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task bus_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clock);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= 1'b1;
        do @(posedge clock); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask : bus_wr

    task bus_rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clock);
        address <= a;
        read <= 1'b1;
        do @(posedge clock); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
    endtask : bus_rd

    task expect_rd(input logic [4:0] a, input logic [31:0] e);
        bus_rd(a, v);
        `CHK(v, e)
    endtask : expect_rd

    task chk_head;
        bus_rd(`OFS_STATUS, v);
        `CHK(v[3:0], exp_head[3:0])
    endtask : chk_head

    // rec says whether the stack is expected to take this branch
    task br(input branch_kind_t k, input logic r0, input logic tk, input logic mp, input logic rec);
        id++;
        u_core.retire(tk, mp, r0, k, src_of(id), tgt_of(id), gpr_of(id), slow ? id % 3 : 0);
        if (rec)
            exp_head++;
    endtask : br

    task wait_armed;
        v = 32'h0;
        for (int n = 0; n < 20 && v[`STATUS_ARMED] !== 1'b1; n++)
            bus_rd(`OFS_STATUS, v);
        `CHK(v[`STATUS_ARMED], 1'b1)
        `CHK(v[`STATUS_FROZEN], 1'b1)
        `CHK(v[3:0], exp_head[3:0])
    endtask : wait_armed

    always @(posedge clock)
    begin
        if (sample_valid === 1'b1)
        begin
            n_samp++;
            smp_ip = sample_ip;
            smp_gpr = sample_gpr;
        end
        if (rstn)
            `CHK(perf_monitor_interrupt, sample_valid)
    end

    // the whole run needs well under two thousand cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_fail++;
            end_sim();
        end
    end

    initial
    begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        expect_rd(`OFS_FILTER, 32'h0);
        expect_rd(`OFS_EVTSEL, 32'h0);
        expect_rd(`OFS_COUNT, 32'h0);
        expect_rd(`OFS_STATUS, 32'h0);
        expect_rd(5'h1c, 32'h0);
        bus_wr(`OFS_FILTER, 32'hffff_ffff, 4'hf);
        expect_rd(`OFS_FILTER, 32'h1ff);
        bus_wr(`OFS_FILTER, 32'h0, 4'h1);
        expect_rd(`OFS_FILTER, 32'h100);
        bus_wr(`OFS_FILTER, 32'h0, 4'hf);
        // seventeen branches wrap the stack once
        for (int i = 0; i < 17; i++)
            br(kind_rel_jump, 1'b1, 1'b1, 1'b0, 1'b1);
        chk_head();
        bus_wr(`OFS_RDIDX, 32'h0, 4'hf);
        expect_rd(`OFS_RDSRC, src_of(17));
        expect_rd(`OFS_RDTGT, tgt_of(17));
        bus_wr(`OFS_RDIDX, 32'h1, 4'hf);
        expect_rd(`OFS_RDSRC, src_of(2));
        br(kind_cond, 1'b1, 1'b0, 1'b0, 1'b0);
        chk_head();
        slow = 1'b1;
        for (int b = 0; b < `FILTER_W; b++)
        begin
            bus_wr(`OFS_FILTER, 32'h1 << b, 4'hf);
            if (b < 2)
            begin
                br(kind_rel_jump, b == 0, 1'b1, 1'b0, 1'b0);
                br(kind_rel_jump, b != 0, 1'b1, 1'b0, 1'b1);
            end
            else
            begin
                br(branch_kind_t'(3'(b - 2)), 1'b1, 1'b1, 1'b0, 1'b0);
                br(branch_kind_t'(3'((b - 1) % 7)), 1'b1, 1'b1, 1'b0, 1'b1);
            end
            chk_head();
        end
        bus_wr(`OFS_FILTER, 32'h0, 4'hf);
        for (int u = 0; u < 3; u++)
            for (int m = 0; m < 2; m++)
            begin
                bus_wr(`OFS_COUNT, 32'h0, 4'hf);
                bus_wr(`OFS_EVTSEL, evt(um_tab[u], m[0], `EVT_CODE_BRANCH), 4'hf);
                br(kind_cond, 1'b1, 1'b1, 1'b1, 1'b1);
                br(kind_rel_call, 1'b0, 1'b1, 1'b0, 1'b1);
                br(kind_ind_call, 1'b1, 1'b1, 1'b0, 1'b1);
                br(kind_far, 1'b0, 1'b1, 1'b0, 1'b1);
                expect_rd(`OFS_COUNT, m ? misp_tab[u] : all_tab[u]);
            end
        bus_wr(`OFS_COUNT, 32'h0, 4'hf);
        bus_wr(`OFS_EVTSEL, evt(8'h04, 1'b0, 8'hc0), 4'hf);
        br(kind_cond, 1'b1, 1'b1, 1'b0, 1'b1);
        expect_rd(`OFS_COUNT, 32'h0);
        slow = 1'b0;
        // overflow, then a branch inside the shadow and the freeze delay
        bus_wr(`OFS_COUNT, 32'hffff_ffff, 4'hf);
        bus_wr(`OFS_EVTSEL, evt(8'h04, 1'b0, `EVT_CODE_BRANCH), 4'hf);
        n0 = n_samp;
        br(kind_rel_jump, 1'b1, 1'b1, 1'b0, 1'b1);
        br(kind_rel_jump, 1'b1, 1'b1, 1'b0, 1'b1);
        `CHK(n_samp, n0)
        wait_armed();
        bus_wr(`OFS_EVTSEL, evt(8'h01, 1'b0, `EVT_CODE_BRANCH), 4'hf);
        br(kind_rel_jump, 1'b1, 1'b1, 1'b0, 1'b0);
        chk_head();
        bus_wr(`OFS_STATUS, 32'h10, 4'hf);
        br(kind_cond, 1'b0, 1'b1, 1'b1, 1'b1);
        repeat (3) @(posedge clock);
        `CHK(n_samp, n0 + 1)
        `CHK(smp_ip, tgt_of(id))
        `CHK(smp_gpr, gpr_of(id))
        bus_wr(`OFS_RDIDX, 32'(exp_head - 1) & 32'hf, 4'hf);
        expect_rd(`OFS_RDTGT, tgt_of(id));
        // second overflow, then a sampled conditional that falls through
        bus_wr(`OFS_COUNT, 32'hffff_ffff, 4'hf);
        br(kind_cond, 1'b1, 1'b1, 1'b0, 1'b1);
        wait_armed();
        bus_wr(`OFS_STATUS, 32'h10, 4'hf);
        br(kind_cond, 1'b1, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge clock);
        `CHK(n_samp, n0 + 2)
        `CHK(smp_ip, src_of(id) + 32'h4)
        chk_head();
        end_sim();
    end
endmodule : branch_trace_sampler_tb
`default_nettype wire
